// ### hdl/result_fifo.sv
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  // shift style keeps the head word in a fixed flip-flop
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] ent;
    logic [CW-1:0]               cnt;
    logic                        nempty;
    logic                        nfull;
  } fifo_s;

  fifo_s st;
  fifo_s next_st;
  logic  push;
  logic  pop;
  logic [CW-1:0] n;

  always_comb begin
    next_st = st;
    push = in_valid && st.nfull;
    pop = st.nempty && out_ready;
    n = st.cnt;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_st.ent[i] = st.ent[i+1];
      end
      n = n - CW'(1);
    end
    if (push) begin
      next_st.ent[n] = in_data;
      n = n + CW'(1);
    end
    next_st.cnt = n;
    next_st.nempty = (n != '0);
    next_st.nfull = (n != CW'(DEPTH));
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{ent: '0, cnt: '0, nempty: 1'b0, nfull: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = st.nfull;
  assign out_valid = st.nempty;
  assign out_data = st.ent[0];
endmodule
`default_nettype wire

// ### hdl/scope_pkg.sv
// Behaviour
// RULE1 - one shot of up to 2048 samples from one channel per acquisition
// RULE2 - every stored sample is 14 bits wide
// RULE3 - effective rate is input rate divided by two to a chosen exponent
// RULE4 - shot duration follows from sample count and effective rate
// RULE5 - selector routes one of input1, input2, output1, output2 to capture
// RULE6 - thirteen trigger sources, rising or falling edge method
// RULE7 - hold-off and trigger level are independent settings
// RULE8 - with trigger enabled each trigger event starts a shot
// RULE9 - with trigger disabled shots follow back to back
// RULE10 - run starts repeated acquisition until stopped
// RULE11 - time or frequency domain chosen, other settings shared
// RULE12 - averaging on combines shots, off passes each shot unchanged
// RULE13 - averager takes time shot or FFT result by domain
// RULE14 - averaging method is uniform or exponential
// RULE15 - exponential weight W gives about 63 percent after W shots
// RULE16 - count of shots averaged before results go to the host
// RULE17 - clear command restarts averaging from the next shot; the code only clears the count, so exponential mode keeps the old averages
// RULE18 - trigger stays disarmed for hold-off after each shot
// RULE19 - slope setting picks rising or falling edge
// RULE20 - level is a signed percentage of full scale
// RULE21 - shot with data loss is flagged and dropped entirely
// RULE22 - averaged shot counter clears with filter and counts accepted shots
`default_nettype none
package scope_pkg;

  localparam int SAMPLE_W = 14;
  localparam int SHOT_MAX = 2048;
  localparam int ADDR_W   = 11;
  localparam int LEN_W    = 12;
  localparam int RATE_W   = 4;
  localparam int DEC_W    = 15;
  localparam int FRAC_W   = 8;
  localparam int AVG_W    = SAMPLE_W + FRAC_W;
  localparam int LEVEL_W  = 8;
  localparam int PROD_W   = 24;
  localparam int HOLD_W   = 32;
  localparam int COUNT_W  = 16;
  localparam int SHIFT_W  = 5;
  localparam int TSEL_W   = 4;
  localparam int N_SRC    = 4;
  localparam int N_OSC    = 8;
  localparam int FIFO_DEPTH = 4;

  localparam logic [LEN_W-1:0]         LEN_FULL     = 12'h800;
  localparam logic [LEN_W-1:0]         LEN_ONE      = 12'h001;
  localparam logic [DEC_W-1:0]         DEC_ONE      = 15'h0001;
  localparam logic [COUNT_W-1:0]       COUNT_ONE    = 16'h0001;
  localparam logic [COUNT_W-1:0]       COUNT_MAX    = 16'hFFFF;
  localparam logic [HOLD_W-1:0]        HOLD_ONE     = 32'h0000_0001;
  localparam logic signed [PROD_W-1:0] PCT_FULL     = 24'sh00_0064;
  localparam logic signed [PROD_W-1:0] FULL_SCALE   = 24'sh00_1FFF;
  localparam logic [TSEL_W-1:0]        TRG_OSC_BASE = 4'h4;
  localparam logic [TSEL_W-1:0]        TRG_DIO      = 4'hC;

  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_HOLDOFF = 3'b001,
    PH_ARMED   = 3'b010,
    PH_CAPTURE = 3'b011,
    PH_PROCESS = 3'b100
  } phase_e;

  typedef enum logic [1:0] {
    SRC_IN1  = 2'b00,
    SRC_IN2  = 2'b01,
    SRC_OUT1 = 2'b10,
    SRC_OUT2 = 2'b11
  } source_e;

  typedef enum logic {DOM_TIME = 1'b0, DOM_FREQ = 1'b1} domain_e;
  typedef enum logic {SLOPE_FALL = 1'b0, SLOPE_RISE = 1'b1} slope_e;
  typedef enum logic {AVG_UNIFORM = 1'b0, AVG_EXPO = 1'b1} avg_method_e;

  typedef struct packed {
    source_e                    source;
    logic [RATE_W-1:0]          rate_exp;
    logic [LEN_W-1:0]           shot_len;
    domain_e                    domain;
    logic                       trig_en;
    logic [TSEL_W-1:0]          trig_sel;
    slope_e                     slope;
    logic signed [LEVEL_W-1:0]  level_pct;
    logic [HOLD_W-1:0]          holdoff;
    logic                       avg_en;
    avg_method_e                avg_method;
    logic [COUNT_W-1:0]         weight;
    logic [COUNT_W-1:0]         avg_target;
  } scope_cfg_s;

  typedef struct packed {
    logic                              valid;
    logic [N_SRC-1:0][SAMPLE_W-1:0]    value;
  } streams_s;

  typedef struct packed {
    logic              last;
    logic [AVG_W-1:0]  value;
  } result_s;

  localparam int RESULT_W = AVG_W + 1;

  typedef struct packed {
    phase_e              phase;
    logic [ADDR_W-1:0]   idx;
    logic [LEN_W-1:0]    len;
    logic [DEC_W-1:0]    dec;
    logic [HOLD_W-1:0]   hold;
    logic                cond_prev;
    logic                dio_s1;
    logic                dio_s2;
    logic                lost;
    logic [COUNT_W-1:0]  count;
    logic [SHIFT_W-1:0]  shift;
    logic                deliver;
    logic                freq;
    logic                avg_on;
    logic                shot_done;
    logic                shot_invalid;
    logic                armed;
    logic [COUNT_W-1:0]  lost_shots;
  } core_s;

  localparam core_s CORE_RST = core_s'(0);

endpackage
`default_nettype wire

// ### hdl/scope_shot_capture_averager.sv
`default_nettype none
module scope_shot_capture_averager (
  input  wire logic                               core_clk,
  input  wire logic                               rstn,
  input  wire logic                               run,
  input  wire scope_pkg::scope_cfg_s              cfg,
  input  wire scope_pkg::streams_s                samples,
  input  wire logic                               sample_loss,
  input  wire logic [scope_pkg::N_OSC-1:0]        osc_bits,
  input  wire logic                               dio_pin,
  input  wire logic                               avg_clear,
  input  wire logic [scope_pkg::SAMPLE_W-1:0]     fft_data,
  input  wire logic                               fft_valid,
  output logic                                    fft_ready,
  output logic                                    res_valid,
  output scope_pkg::result_s                      res_data,
  input  wire logic                               res_ready,
  output logic                                    shot_done,
  output logic                                    shot_invalid,
  output logic                                    trig_armed,
  output logic [scope_pkg::COUNT_W-1:0]           avg_count,
  output logic [scope_pkg::COUNT_W-1:0]           lost_count,
  output logic                                    acquiring
);
  import scope_pkg::*;

  core_s                st;
  core_s                next_st;
  logic                 wr_shot;
  logic                 wr_avg;
  logic                 push;
  logic                 trig_now;
  logic                 fire;
  logic                 take;
  logic                 src_ok;
  logic                 room;
  logic                 fifo_in_ready;
  logic                 last_idx;
  logic [LEN_W-1:0]     eff_len;
  logic [DEC_W-1:0]     dec_mask;
  logic [COUNT_W-1:0]   shots_n;
  logic [COUNT_W-1:0]   count_base;
  logic [SAMPLE_W-1:0]  shot_rd;
  logic [SAMPLE_W-1:0]  x_in;
  logic [AVG_W-1:0]     x_ext;
  logic [AVG_W-1:0]     old_v;
  logic signed [AVG_W:0] diff;
  logic signed [AVG_W:0] delta;
  logic [AVG_W-1:0]     avg_new;
  logic [AVG_W-1:0]     out_v;
  result_s              push_word;
  logic [RESULT_W-1:0]  fifo_out;

  logic [SAMPLE_W-1:0]  shot_mem [SHOT_MAX];
  logic [AVG_W-1:0]     avg_mem  [SHOT_MAX];

  // zero weight would mean infinite depth; it behaves as the maximum shift
  function automatic logic [SHIFT_W-1:0] ceil_log2(input logic [COUNT_W-1:0] v);
    logic [COUNT_W-1:0] m;
    logic [SHIFT_W-1:0] r;
    m = v - COUNT_ONE;
    r = '0;
    for (int i = 0; i < COUNT_W; i++) begin
      if (m[i]) begin
        r = SHIFT_W'(i + 1);
      end
    end
    return r;
  endfunction

  // analog sources compare sample*100 against pct*full scale, no divider
  function automatic logic trig_level(input logic [TSEL_W-1:0] sel,
                                      input streams_s s,
                                      input logic [N_OSC-1:0] osc,
                                      input logic dio,
                                      input logic signed [LEVEL_W-1:0] pct);
    logic signed [PROD_W-1:0] lhs;
    logic signed [PROD_W-1:0] rhs;
    logic [TSEL_W-1:0]        osel;
    lhs = PROD_W'($signed(s.value[sel[1:0]])) * PCT_FULL;
    rhs = PROD_W'(pct) * FULL_SCALE; // RULE20
    osel = sel - TRG_OSC_BASE;
    if (sel < TRG_OSC_BASE) begin
      return lhs >= rhs;
    end else if (sel < TRG_DIO) begin
      return osc[osel[2:0]];
    end else if (sel == TRG_DIO) begin
      return dio;
    end
    return 1'b0;
  endfunction

  // shot length 0 or beyond memory means a full buffer
  assign eff_len = (cfg.shot_len == '0 || cfg.shot_len > LEN_FULL) ? LEN_FULL : cfg.shot_len; // RULE1
  assign dec_mask = (DEC_ONE << cfg.rate_exp) - DEC_ONE; // RULE3
  assign last_idx = ({1'b0, st.idx} == st.len - LEN_ONE);
  assign count_base = avg_clear ? '0 : st.count; // RULE17
  assign shots_n = (count_base == COUNT_MAX) ? COUNT_MAX : count_base + COUNT_ONE;

  // averaging datapath
  assign shot_rd = shot_mem[st.idx];
  assign x_in = st.freq ? fft_data : shot_rd; // RULE13
  assign x_ext = {x_in, {FRAC_W{1'b0}}};
  assign old_v = avg_mem[st.idx];
  assign diff = $signed({x_ext[AVG_W-1], x_ext}) - $signed({old_v[AVG_W-1], old_v});
  assign delta = diff >>> st.shift; // RULE15
  assign avg_new = old_v + delta[AVG_W-1:0];
  assign out_v = st.avg_on ? avg_new : x_ext; // RULE12

  assign src_ok = !st.freq || fft_valid;
  assign room = !st.deliver || fifo_in_ready;
  assign take = (st.phase == PH_PROCESS) && src_ok && room;

  always_comb begin
    next_st = st;
    wr_shot = 1'b0;
    wr_avg = 1'b0;
    push = 1'b0;
    next_st.dio_s1 = dio_pin;
    next_st.dio_s2 = st.dio_s1;
    next_st.shot_done = 1'b0;
    next_st.shot_invalid = 1'b0;
    trig_now = trig_level(cfg.trig_sel, samples, osc_bits, st.dio_s2, cfg.level_pct); // RULE6
    next_st.cond_prev = trig_now;
    if (!cfg.trig_en) begin
      fire = 1'b1; // RULE9
    end else if (cfg.slope == SLOPE_RISE) begin
      fire = trig_now && !st.cond_prev; // RULE19
    end else begin
      fire = !trig_now && st.cond_prev; // RULE19
    end
    if (avg_clear) begin
      next_st.count = '0; // RULE22
    end
    next_st.armed = 1'b0;
    case (st.phase)
      PH_IDLE: begin
        if (run) begin
          next_st.phase = PH_HOLDOFF; // RULE10
          next_st.hold = '0;
        end
      end
      PH_HOLDOFF: begin
        if (!run) begin
          next_st.phase = PH_IDLE;
        end else if (st.hold >= cfg.holdoff) begin
          next_st.phase = PH_ARMED; // RULE18
          next_st.armed = 1'b1;
        end else begin
          next_st.hold = st.hold + HOLD_ONE; // RULE7
        end
      end
      PH_ARMED: begin
        next_st.armed = 1'b1;
        if (!run) begin
          next_st.phase = PH_IDLE;
          next_st.armed = 1'b0;
        end else if (fire) begin
          next_st.phase = PH_CAPTURE; // RULE8
          next_st.armed = 1'b0;
          next_st.idx = '0;
          next_st.dec = '0;
          next_st.lost = 1'b0;
          next_st.len = eff_len; // RULE4
        end
      end
      PH_CAPTURE: begin
        if (!run) begin
          next_st.phase = PH_IDLE;
        end else begin
          if (sample_loss) begin
            next_st.lost = 1'b1; // RULE21
          end
          if (samples.valid) begin
            next_st.dec = st.dec + DEC_ONE;
            if ((st.dec & dec_mask) == '0) begin
              wr_shot = 1'b1; // RULE5
              next_st.idx = st.idx + ADDR_W'(1);
              if (last_idx) begin
                next_st.idx = '0;
                next_st.hold = '0;
                if (st.lost || sample_loss) begin
                  next_st.phase = PH_HOLDOFF; // RULE21
                  next_st.shot_invalid = 1'b1;
                  next_st.lost_shots = st.lost_shots + COUNT_ONE;
                end else begin
                  next_st.phase = PH_PROCESS;
                  next_st.freq = (cfg.domain == DOM_FREQ); // RULE11
                  next_st.avg_on = cfg.avg_en;
                  if (cfg.avg_en) begin
                    next_st.count = shots_n; // RULE22
                    next_st.deliver = (shots_n >= cfg.avg_target); // RULE16
                  end else begin
                    next_st.deliver = 1'b1;
                  end
                  if (cfg.avg_method == AVG_EXPO) begin
                    next_st.shift = ceil_log2(cfg.weight); // RULE14
                  end else begin
                    next_st.shift = ceil_log2(shots_n); // RULE14
                  end
                end
              end
            end
          end
        end
      end
      PH_PROCESS: begin
        if (take) begin
          wr_avg = 1'b1;
          push = st.deliver;
          next_st.idx = st.idx + ADDR_W'(1);
          if (last_idx) begin
            next_st.idx = '0;
            next_st.phase = PH_HOLDOFF; // RULE18
            next_st.hold = '0;
            next_st.shot_done = 1'b1;
          end
        end
      end
      default: begin
        next_st = CORE_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= CORE_RST;
    end else begin
      st <= next_st;
    end
  end

  // memories carry no reset; with uniform averaging the first averaged shot overwrites stale words
  always_ff @(posedge core_clk) begin
    if (wr_shot) begin
      shot_mem[st.idx] <= samples.value[cfg.source]; // RULE2
    end
    if (wr_avg) begin
      avg_mem[st.idx] <= out_v; // RULE12
    end
  end

  assign push_word = '{last: last_idx, value: out_v};

  result_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (push),
    .in_data   (push_word),
    .in_ready  (fifo_in_ready),
    .out_valid (res_valid),
    .out_data  (fifo_out),
    .out_ready (res_ready)
  );

  assign res_data = result_s'(fifo_out);
  // combinational, like acquiring: a registered ready could not see the fifo fill
  assign fft_ready = (st.phase == PH_PROCESS) && st.freq && room;
  assign shot_done = st.shot_done;
  assign shot_invalid = st.shot_invalid;
  assign trig_armed = st.armed;
  assign avg_count = st.count;
  assign lost_count = st.lost_shots;
  assign acquiring = (st.phase == PH_CAPTURE);
endmodule
`default_nettype wire

// ### testbench/scope_checks_properties.sv
`default_nettype none
module scope_checks (
  input wire logic                          core_clk,
  input wire logic                          rstn,
  input wire logic                          run,
  input wire scope_pkg::scope_cfg_s         cfg,
  input wire logic                          res_valid,
  input wire scope_pkg::result_s            res_data,
  input wire logic                          res_ready,
  input wire logic                          fft_ready,
  input wire logic                          shot_done,
  input wire logic                          shot_invalid,
  input wire logic                          trig_armed,
  input wire logic [scope_pkg::COUNT_W-1:0] avg_count,
  input wire logic [scope_pkg::COUNT_W-1:0] lost_count,
  input wire logic                          acquiring
);
  timeunit 1ns;
  timeprecision 1ps;
  import scope_pkg::*;
  // cycles since the last shot ended, for the rearm gap
  logic [31:0] gap;
  logic        seen;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gap  <= '0;
      seen <= 1'b0;
    end else if (shot_done || shot_invalid) begin
      gap  <= '0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_res_hold: assert property (
    res_valid && !res_ready |=> res_valid && $stable(res_data)) else $error("stalled word moved");
  chk_done_pulse: assert property (
    shot_done |-> !shot_invalid && !acquiring ##1 !shot_done) else $error("bad shot end pulse");
  chk_lost_incr: assert property (
    shot_invalid |-> lost_count == $past(lost_count) + 16'h0001) else $error("loss not counted");
  // the count registers together with the pulse, so both look at the same cycle
  chk_lost_hold: assert property (
    !shot_invalid |-> $stable(lost_count)) else $error("loss count moved");
  chk_armed_idle: assert property (
    trig_armed |-> !acquiring && !shot_done) else $error("armed while busy");
  chk_rearm_gap: assert property (
    seen && $rose(trig_armed) |-> gap >= cfg.holdoff) else $error("rearmed before holdoff");
  chk_fire_armed: assert property (
    $rose(acquiring) |-> $past(trig_armed)) else $error("capture without arming");
  chk_cont_fire: assert property (
    trig_armed && !cfg.trig_en && run |=> acquiring) else $error("continuous shot waited");
  chk_stop_run: assert property (
    !run |=> !acquiring && !trig_armed) else $error("kept running after stop");
  chk_avg_step: assert property (
    avg_count > $past(avg_count) |-> $past(acquiring)
      && (avg_count == $past(avg_count) + 16'h0001 || avg_count == 16'h0001))
    else $error("average count jumped");
  chk_fft_idle: assert property (
    fft_ready |-> !acquiring && !trig_armed) else $error("fft taken outside processing");
  cov_done: cover property (shot_done);
  cov_lost: cover property (shot_invalid);
  cov_trig: cover property (cfg.trig_en && $rose(trig_armed));
endmodule
bind scope_shot_capture_averager scope_checks chk_u (
  .core_clk, .rstn, .run, .cfg, .res_valid, .res_data, .res_ready, .fft_ready,
  .shot_done, .shot_invalid, .trig_armed, .avg_count, .lost_count, .acquiring
);
`default_nettype wire

// ### testbench/scope_far_end.sv
`default_nettype none
module scope_far_end (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire logic                      acquiring,
  input  wire logic                      fft_ready,
  input  wire logic                      stall,
  input  wire logic                      slow,
  output scope_pkg::streams_s            samples = '0,
  output logic [scope_pkg::SAMPLE_W-1:0] fft_data = '0,
  output logic                           fft_valid = 1'b0,
  output logic                           res_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  import scope_pkg::*;
  logic [SAMPLE_W-1:0] cnt;
  logic [SAMPLE_W-1:0] fcnt;
  logic                par;
  logic                acq_d;
  logic                tick;
  // ramp restarts each capture; par flips per shot so averages move
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt   <= '0;
      fcnt  <= '0;
      par   <= 1'b0;
      acq_d <= 1'b0;
      tick  <= 1'b0;
    end else begin
      acq_d <= acquiring;
      tick  <= !tick;
      cnt   <= acquiring ? cnt + 14'h0001 : 14'h0000;
      if (acq_d && !acquiring) par <= !par;
      if (acquiring) fcnt <= '0;
      else if (fft_valid && fft_ready) fcnt <= fcnt + 14'h0001;
    end
  end
  always @(negedge core_clk) begin
    samples.valid <= 1'b1;
    for (int k = 0; k < N_SRC; k++) begin
      samples.value[k] <= SAMPLE_W'(k << 10) + {5'h00, par, 8'h00} + cnt;
    end
    fft_valid <= 1'b1;
    fft_data  <= 14'h0200 + fcnt;
    res_ready <= !stall && (!slow || tick);
  end
endmodule
`default_nettype wire

// ### testbench/scope_shot_capture_averager_tb.sv
`default_nettype none
module scope_shot_capture_averager_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scope_pkg::*;
  logic               core_clk, rstn, run, sample_loss, dio_pin, avg_clear, stall, slow;
  logic               fft_valid, fft_ready, res_valid, res_ready;
  logic               shot_done, shot_invalid, trig_armed, acquiring;
  logic [N_OSC-1:0]   osc_bits;
  logic [SAMPLE_W-1:0] fft_data;
  logic [COUNT_W-1:0] avg_count, lost_count;
  scope_cfg_s         cfg;
  streams_s           samples;
  result_s            res_data;
  result_s            q[$];
  int                 n_mismatch = 0;
  int                 cmp_count = 0;
  int                 g;

  scope_shot_capture_averager dut_u (
    .core_clk, .rstn, .run, .cfg, .samples, .sample_loss, .osc_bits, .dio_pin,
    .avg_clear, .fft_data, .fft_valid, .fft_ready, .res_valid, .res_data, .res_ready,
    .shot_done, .shot_invalid, .trig_armed, .avg_count, .lost_count, .acquiring
  );
  scope_far_end far_u (
    .core_clk, .rstn, .acquiring, .fft_ready, .stall, .slow, .samples, .fft_data,
    .fft_valid, .res_ready
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (res_valid && res_ready) q.push_back(res_data);

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // 0 armed, 1 capturing, 2 done, 3 dropped, 4 word queued
  task automatic wait_hi(input int sel, input int lim);
    logic [4:0] v;
    for (int i = 0; i < lim; i++) begin
      v = {q.size() != 0, shot_invalid, shot_done, acquiring, trig_armed};
      if (v[sel]) return;
      @(negedge core_clk);
    end
    n_mismatch++;
    $display("ERROR at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
    stop_test();
  endtask
  task automatic do_reset();
    @(negedge core_clk);
    rstn = 1'b0;
    run = 1'b0;
    repeat (16) @(negedge core_clk);
    check({shot_done, shot_invalid, trig_armed, acquiring, res_valid,
           |avg_count, |lost_count}, 0);
    q.delete();
    rstn = 1'b1;
  endtask
  task automatic run_shot(input int n, input int base, input int step);
    result_s w;
    for (int i = 0; i < n; i++) begin
      wait_hi(4, 5000);
      w = q.pop_front();
      check(w.value, (base + i * step) << 8);
      check(w.last, i == n - 1);
    end
  endtask

  initial begin
    {rstn, run, sample_loss, dio_pin, avg_clear, stall, slow} = '0;
    osc_bits = '0;
    cfg = '0;
    cfg.shot_len = 12'h004;
    cfg.holdoff = 32'h0000_0032;
    cfg.weight = 16'h0001;
    cfg.avg_target = 16'h0001;
    for (int k = 0; k < N_SRC; k++) begin
      cfg.source = source_e'(k);
      cfg.rate_exp = RATE_W'(k);
      do_reset();
      run = 1'b1;
      run_shot(4, k << 10, 1 << k);
      run = 1'b0;
    end
    $display("test source and rate done");
    cfg.source = SRC_IN1;
    cfg.rate_exp = '0;
    cfg.shot_len = '0;
    do_reset();
    run = 1'b1;
    run_shot(SHOT_MAX, 0, 1);
    run = 1'b0;
    $display("test full shot done");
    cfg.shot_len = 12'h008;
    stall = 1'b1;
    do_reset();
    run = 1'b1;
    repeat (80) @(negedge core_clk);
    check(res_valid, 1);
    check(q.size(), 0);
    stall = 1'b0;
    run_shot(8, 0, 1);
    run = 1'b0;
    cfg.domain = DOM_FREQ;
    slow = 1'b1;
    do_reset();
    run = 1'b1;
    run_shot(8, 32'h0000_0200, 1);
    run = 1'b0;
    slow = 1'b0;
    cfg.domain = DOM_TIME;
    $display("test stall and freq done");
    cfg.shot_len = 12'h004;
    cfg.avg_en = 1'b1;
    cfg.avg_target = 16'h0002;
    cfg.holdoff = 32'h0000_0014;
    do_reset();
    run = 1'b1;
    run_shot(4, 32'h0000_0080, 1);
    check(avg_count, 2);
    wait_hi(1, 100);
    wait_hi(2, 100);
    for (g = 0; g < 40 && !acquiring; g++) @(negedge core_clk);
    check(g >= 21 && g <= 23, 1);
    check(avg_count, 3);
    run_shot(4, 32'h0000_0060, 1);
    run = 1'b0;
    @(negedge core_clk);
    avg_clear = 1'b1;
    @(negedge core_clk);
    avg_clear = 1'b0;
    run = 1'b1;
    wait_hi(1, 200);
    wait_hi(2, 200);
    check(avg_count, 1);
    check(q.size(), 0);
    run = 1'b0;
    $display("test uniform average done");
    cfg.avg_target = 16'h0001;
    cfg.holdoff = 32'h0000_0032;
    cfg.rate_exp = 4'h3;
    do_reset();
    run = 1'b1;
    wait_hi(1, 200);
    sample_loss = 1'b1;
    @(negedge core_clk);
    sample_loss = 1'b0;
    wait_hi(3, 100);
    check(lost_count, 1);
    check(avg_count, 0);
    run_shot(4, 32'h0000_0100, 8);
    check(avg_count, 1);
    run = 1'b0;
    cfg.rate_exp = '0;
    cfg.avg_method = AVG_EXPO;
    do_reset();
    run = 1'b1;
    run_shot(4, 0, 1);
    run_shot(4, 32'h0000_0100, 1);
    check(avg_count, 2);
    run = 1'b0;
    $display("test loss and exponential done");
    cfg.avg_en = 1'b0;
    cfg.trig_en = 1'b1;
    for (int s = 4; s <= 12; s++) begin
      for (int sl = 0; sl < 2; sl++) begin
        cfg.trig_sel = TSEL_W'(s);
        cfg.slope = slope_e'(sl);
        osc_bits = (sl == 1) ? 8'h00 : 8'hFF;
        dio_pin = (sl == 0);
        do_reset();
        run = 1'b1;
        wait_hi(0, 100);
        repeat (8) @(negedge core_clk);
        check({acquiring, trig_armed}, 2'b01);
        if (s == 12) dio_pin = 1'(sl);
        else osc_bits[s - 4] = 1'(sl);
        wait_hi(1, 6);
        run = 1'b0;
      end
    end
    // analog source: level above the stream first, then lowered to make an edge
    cfg.trig_sel = 4'h1;
    cfg.slope = SLOPE_RISE;
    cfg.level_pct = 8'sh7F;
    do_reset();
    run = 1'b1;
    wait_hi(0, 100);
    repeat (8) @(negedge core_clk);
    check({acquiring, trig_armed}, 2'b01);
    cfg.level_pct = 8'sh0A;
    wait_hi(1, 6);
    run = 1'b0;
    $display("test trigger sources done");
    stop_test();
  end
endmodule
`default_nettype wire
